// file: tb/fsp_cpu_model.sv
/*
 CPU-side model: user program and library issuing one-cycle commands.
 Assumes the controller samples commands on the rising edge of clk.
*/
`timescale 1ns/100ps
module fsp_cpu_model (
	input wire logic clk,
	output logic mode_enter,
	output logic mode_exit,
	output logic op_start,
	output logic [1:0] op_code,
	output logic [15:0] op_addr,
	output logic [7:0] op_wdata
);
	// ===========================================
	// Idle levels; all command strobes low, code, address and data zero
	initial begin
		{mode_enter, mode_exit, op_start} = 3'h0;
		op_code = 2'h0;
		op_addr = 16'h0000;
		op_wdata = 8'h00;
	end
	// One command held for one cycle, then the strobes drop and the code, address and data lines show the inverse
	task automatic cmd(input logic [2:0] k, input logic [1:0] c, input logic [15:0] a);
		@(posedge clk);
		{mode_enter, mode_exit, op_start} <= k;
		op_code <= c;
		op_addr <= a;
		op_wdata <= a[7:0] ^ 8'hA5;
		@(posedge clk);
		{mode_enter, mode_exit, op_start} <= 3'h0;
		op_code <= ~c;
		op_addr <= ~a;
		op_wdata <= ~(a[7:0] ^ 8'hA5);
		#1;
	endtask
endmodule

// file: tb/tb_top.sv
/*
 Testbench of the flash self-programming controller.
 Assumes fsp_cpu_model as the CPU side and shortened busy counts.
*/
`timescale 1ns/100ps
module tb_top;
	logic clk, resetn, pin, subclk, prot;
	logic [31:0] irq_req, irq_msk;
	logic mode_enter, mode_exit, op_start;
	logic [1:0] op_code;
	logic [15:0] op_addr, flash_addr;
	logic [7:0] op_wdata, flash_wdata;
	logic mode_active, op_busy, op_done, op_refused, irq_stopped, erase_en, write_en;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	// ===========================================
	// Instances
	fsp_cpu_model i_cpu (.clk(clk), .mode_enter(mode_enter), .mode_exit(mode_exit),
		.op_start(op_start), .op_code(op_code), .op_addr(op_addr), .op_wdata(op_wdata));
	fsp_ctrl #(.ERASE_CYC(4), .WRITE_CYC(2)) i_dut (.clk(clk), .resetn(resetn),
		.flash_mode_select_pin(pin), .cpu_on_subclock(subclk), .boot0_protect(prot),
		.irq_request_flags(irq_req), .irq_mask_flags(irq_msk), .mode_enter(mode_enter),
		.mode_exit(mode_exit), .op_start(op_start), .op_code(op_code), .op_addr(op_addr),
		.op_wdata(op_wdata), .mode_active(mode_active), .op_busy(op_busy),
		.op_done(op_done), .op_refused(op_refused), .irq_stopped(irq_stopped),
		.flash_erase_en(erase_en), .flash_write_en(write_en), .flash_addr(flash_addr),
		.flash_wdata(flash_wdata));
	// ===========================================
	// Clock and cycle ceiling
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			give_verdict();
		end
	end
	// ===========================================
	// Tasks
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk_bit(input string s, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %b got %b", s, e, g);
		end
	endtask
	task automatic chk_val(input string s, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	// Waits a bounded time for the completion pulse
	task automatic wait_done();
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 40 && !seen; i++) begin
			step(1);
			if (op_done === 1'b1) seen = 1'b1;
		end
		chk_bit("op_done", 1'b1, seen);
	endtask
	task automatic enter(input logic e);
		i_cpu.cmd(3'h4, 2'h0, 16'h0000);
		step(1);
		chk_bit("mode_active", e, mode_active);
	endtask
	// Issues an operation; refused ones pulse op_refused, others run to completion
	task automatic start(input logic [1:0] c, input logic [15:0] a, input logic r);
		i_cpu.cmd(3'h1, c, a);
		chk_bit("op_refused", r, op_refused);
		if (!r) begin
			step(1);
			chk_bit("op_busy", 1'b1, op_busy);
			chk_bit("erase_en", c == 2'h1, erase_en);
			chk_bit("write_en", c == 2'h2, write_en);
			chk_val("flash_addr", a, flash_addr);
			if (c == 2'h2) chk_val("flash_wdata", {8'h00, a[7:0] ^ 8'hA5}, {8'h00, flash_wdata});
			wait_done();
		end
	endtask
	// ===========================================
	// Main sequence
	initial begin
		{resetn, pin, subclk, prot} = 4'h0;
		irq_req = 32'h0000_0000;
		irq_msk = 32'h0000_0000;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		step(3);
		chk_bit("irq_stopped", 1'b0, irq_stopped);
		enter(1'b0);
		@(posedge clk);
		{pin, subclk} <= 2'h3;
		step(3);
		enter(1'b0);
		@(posedge clk);
		subclk <= 1'b0;
		step(1);
		enter(1'b1);
		start(2'h1, 16'h8000, 1'b0);
		start(2'h2, 16'h1234, 1'b0);
		start(2'h3, 16'h9000, 1'b1);
		@(posedge clk);
		prot <= 1'b1;
		start(2'h2, 16'h0FFF, 1'b1);
		start(2'h1, 16'h0000, 1'b1);
		start(2'h1, 16'h1000, 1'b0);
		// Each flag byte in turn blocks a start while unmasked
		for (int b = 0; b < 4; b++) begin
			@(posedge clk);
			irq_req <= 32'h0000_0008 << (8 * b);
			start(2'h2, 16'h2000, 1'b1);
		end
		@(posedge clk);
		irq_req <= 32'h0804_0201;
		irq_msk <= 32'h0804_0201;
		start(2'h2, 16'h2001, 1'b0);
		@(posedge clk);
		{irq_req, irq_msk} <= 64'h0;
		i_cpu.cmd(3'h1, 2'h1, 16'h3000);
		step(1);
		chk_bit("op_busy", 1'b1, op_busy);
		@(posedge clk);
		irq_req <= 32'h0001_0000;
		step(2);
		chk_bit("irq_stopped", 1'b1, irq_stopped);
		chk_bit("op_busy", 1'b0, op_busy);
		chk_bit("erase_en", 1'b0, erase_en);
		// Request serviced in normal mode before the mode is re-entered
		@(posedge clk);
		irq_req <= 32'h0000_0000;
		i_cpu.cmd(3'h4, 2'h0, 16'h0000);
		wait_done();
		chk_bit("irq_stopped", 1'b0, irq_stopped);
		i_cpu.cmd(3'h2, 2'h0, 16'h0000);
		step(1);
		chk_bit("mode_active", 1'b0, mode_active);
		enter(1'b1);
		// Select pin dropped mid-erase: the operation is cut and the mode left
		i_cpu.cmd(3'h1, 2'h1, 16'h4000);
		@(posedge clk);
		pin <= 1'b0;
		step(3);
		chk_bit("op_done", 1'b0, op_done);
		chk_bit("erase_en", 1'b0, erase_en);
		step(1);
		chk_bit("mode_active", 1'b0, mode_active);
		// Outside the mode every start is refused
		start(2'h2, 16'h5000, 1'b1);
		@(posedge clk);
		pin <= 1'b1;
		step(3);
		enter(1'b1);
		@(posedge clk);
		subclk <= 1'b1;
		step(3);
		chk_bit("mode_active", 1'b0, mode_active);
		give_verdict();
	end
endmodule

// file: verilog/fsp_ctrl.sv
/*
 Flash self-programming controller: mode entry, erase and write sequencing,
 interrupt stop and resume, boot cluster 0 protection.
 Assumes a CPU-side library driving the command ports on clk, and the
 interrupt flag and mask bytes coming from the interrupt controller on clk.
*/
`timescale 1ns/100ps
`include "fsp_ctrl_map.svh"
module fsp_ctrl #(
	parameter int ADDR_W = `FSP_ADDR_W,
	parameter int IRQ_W = `FSP_IRQ_W,
	parameter int ERASE_CYC = `FSP_ERASE_CYC,
	parameter int WRITE_CYC = `FSP_WRITE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic flash_mode_select_pin,
	input wire logic cpu_on_subclock,
	input wire logic boot0_protect,
	input wire logic [IRQ_W-1:0] irq_request_flags,
	input wire logic [IRQ_W-1:0] irq_mask_flags,
	input wire logic mode_enter,
	input wire logic mode_exit,
	input wire logic op_start,
	input wire logic [1:0] op_code,
	input wire logic [ADDR_W-1:0] op_addr,
	input wire logic [7:0] op_wdata,
	output logic mode_active,
	output logic op_busy,
	output logic op_done,
	output logic op_refused,
	output logic irq_stopped,
	output logic flash_erase_en,
	output logic flash_write_en,
	output logic [ADDR_W-1:0] flash_addr,
	output logic [7:0] flash_wdata
);
	// ===========================================
	// Declarations
	fsp_pkg::fsp_state_t state_q;
	fsp_pkg::fsp_op_t op_q;
	logic [31:0] cnt_q;
	logic [31:0] op_len;
	logic mode_pin_s;
	logic irq_hit;
	logic boot0_hit;
	logic start_ok;
	logic start_acc;

	// ===========================================
	// Pin synchroniser for the mode select input
	fsp_sync #(
		.RESET_VAL(1'b0)
	) u_mode_sync (
		.clk(clk),
		.resetn(resetn),
		.din(flash_mode_select_pin),
		.dout(mode_pin_s)
	);

	// ===========================================
	// Stop conditions and start checks
	// Unmasked request stops regardless of the global mask state
	assign irq_hit = |(irq_request_flags & ~irq_mask_flags);
	assign boot0_hit = boot0_protect && (op_addr <= ADDR_W'(`FSP_BOOT0_HI));
	assign start_ok = op_start && !boot0_hit && !irq_hit &&
		((op_code == fsp_pkg::FSP_OP_ERASE) || (op_code == fsp_pkg::FSP_OP_WRITE));
	// Accepted only in READY when the mode is not being left in the same cycle
	assign start_acc = (state_q == fsp_pkg::FSP_READY) && start_ok && !mode_exit &&
		mode_pin_s && !cpu_on_subclock;
	assign op_len = (op_q == fsp_pkg::FSP_OP_ERASE) ? 32'(ERASE_CYC) : 32'(WRITE_CYC);

	// ===========================================
	// Mode and operation sequencer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= fsp_pkg::FSP_IDLE;
		end else begin
			case (state_q)
				fsp_pkg::FSP_IDLE: begin
					// Entry needs main clock and the select pin high
					if (mode_enter && !cpu_on_subclock && mode_pin_s) begin
						state_q <= fsp_pkg::FSP_READY;
					end
				end
				fsp_pkg::FSP_READY: begin
					if (mode_exit || !mode_pin_s || cpu_on_subclock) begin
						state_q <= fsp_pkg::FSP_IDLE;
					end else if (start_ok) begin
						state_q <= fsp_pkg::FSP_BUSY;
					end
				end
				fsp_pkg::FSP_BUSY: begin
					if (!mode_pin_s || cpu_on_subclock) begin
						state_q <= fsp_pkg::FSP_IDLE;
					end else if (irq_hit) begin
						state_q <= fsp_pkg::FSP_PAUSED;
					end else if (cnt_q + 32'h1 >= op_len) begin
						state_q <= fsp_pkg::FSP_READY;
					end
				end
				fsp_pkg::FSP_PAUSED: begin
					// Normal mode for servicing; re-entry resumes the held operation
					if (mode_enter && !cpu_on_subclock && mode_pin_s && !irq_hit) begin
						state_q <= fsp_pkg::FSP_BUSY;
					end
				end
				default: begin
					state_q <= fsp_pkg::FSP_IDLE;
				end
			endcase
		end
	end

	// ===========================================
	// Operation latch and busy counter
	always_ff @(posedge clk) begin
		if (!resetn) begin
			op_q <= fsp_pkg::FSP_OP_NONE;
			cnt_q <= 32'h0;
			flash_addr <= '0;
			flash_wdata <= 8'h00;
		end else if (start_acc) begin
			op_q <= fsp_pkg::fsp_op_t'(op_code);
			cnt_q <= 32'h0;
			flash_addr <= op_addr;
			flash_wdata <= op_wdata;
		end else if (state_q == fsp_pkg::FSP_BUSY && !irq_hit) begin
			cnt_q <= cnt_q + 32'h1; // Count holds while paused
		end
	end

	// ===========================================
	// Status outputs, all registered
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode_active <= 1'b0;
			op_busy <= 1'b0;
			op_done <= 1'b0;
			op_refused <= 1'b0;
			flash_erase_en <= 1'b0;
			flash_write_en <= 1'b0;
		end else begin
			mode_active <= (state_q == fsp_pkg::FSP_READY) || (state_q == fsp_pkg::FSP_BUSY);
			// Busy and enables drop at once when the pin falls or the subclock is selected
			op_busy <= (state_q == fsp_pkg::FSP_BUSY) && !irq_hit && mode_pin_s && !cpu_on_subclock;
			op_done <= (state_q == fsp_pkg::FSP_BUSY) && !irq_hit && mode_pin_s &&
				!cpu_on_subclock && (cnt_q + 32'h1 >= op_len);
			op_refused <= op_start && !start_acc;
			flash_erase_en <= (state_q == fsp_pkg::FSP_BUSY) && !irq_hit && mode_pin_s &&
				!cpu_on_subclock && (op_q == fsp_pkg::FSP_OP_ERASE);
			flash_write_en <= (state_q == fsp_pkg::FSP_BUSY) && !irq_hit && mode_pin_s &&
				!cpu_on_subclock && (op_q == fsp_pkg::FSP_OP_WRITE);
		end
	end

	// ===========================================
	// Sticky stop flag: set on interrupt stop, cleared on resume or reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_stopped <= 1'b0;
		end else if (state_q == fsp_pkg::FSP_BUSY && irq_hit) begin
			irq_stopped <= 1'b1;
		end else if (state_q == fsp_pkg::FSP_PAUSED && mode_enter && !irq_hit &&
			mode_pin_s && !cpu_on_subclock) begin
			irq_stopped <= 1'b0;
		end
	end

	// ===========================================
	// Checks
	chk_sub_no_entry: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == fsp_pkg::FSP_IDLE && cpu_on_subclock) |=> state_q == fsp_pkg::FSP_IDLE)
		else $error("mode entered on subclock");
	chk_irq_stops_op: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == fsp_pkg::FSP_BUSY && irq_hit && mode_pin_s && !cpu_on_subclock)
		|=> state_q == fsp_pkg::FSP_PAUSED ##1 !op_busy)
		else $error("interrupt did not stop operation");
	chk_masked_no_stop: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == fsp_pkg::FSP_BUSY && (irq_request_flags & ~irq_mask_flags) == '0 &&
		mode_pin_s && !cpu_on_subclock && cnt_q + 32'h1 < op_len)
		|=> state_q == fsp_pkg::FSP_BUSY)
		else $error("masked request stopped operation");
	chk_boot0_refuse: assert property (@(posedge clk) disable iff (!resetn)
		(op_start && boot0_hit) |=> op_refused && state_q != fsp_pkg::FSP_BUSY)
		else $error("boot cluster 0 access accepted");
	chk_stop_flag: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == fsp_pkg::FSP_PAUSED) |-> irq_stopped)
		else $error("stop flag not shown while paused");
	chk_resume_keeps: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == fsp_pkg::FSP_PAUSED) |=> $stable(cnt_q) && $stable(op_q))
		else $error("paused operation lost");
	chk_write_enable: assert property (@(posedge clk) disable iff (!resetn)
		flash_write_en |-> $past(mode_pin_s) && !$past(cpu_on_subclock, 1))
		else $error("write enabled outside mode");
	chk_pin_low_exit: assert property (@(posedge clk) disable iff (!resetn)
		(!mode_pin_s && state_q != fsp_pkg::FSP_PAUSED) |=> state_q == fsp_pkg::FSP_IDLE)
		else $error("mode kept with select pin low");
	// Abort through pin or subclock leaves no enable behind
	chk_abort_drops: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == fsp_pkg::FSP_BUSY && (!mode_pin_s || cpu_on_subclock))
		|=> !flash_erase_en && !flash_write_en && !op_busy)
		else $error("enable kept after abort");
	chk_irq_no_start: assert property (@(posedge clk) disable iff (!resetn)
		(op_start && irq_hit) |=> op_refused)
		else $error("start accepted with request pending");
	chk_paused_quiet: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == fsp_pkg::FSP_PAUSED) |-> !op_busy && !flash_erase_en && !flash_write_en)
		else $error("flash enabled while paused");
	cov_erase_done: cover property (@(posedge clk) disable iff (!resetn)
		op_done && op_q == fsp_pkg::FSP_OP_ERASE);
	cov_pause_resume: cover property (@(posedge clk) disable iff (!resetn)
		state_q == fsp_pkg::FSP_PAUSED ##1 state_q == fsp_pkg::FSP_BUSY);
	cov_refused: cover property (@(posedge clk) disable iff (!resetn) op_refused);
	cov_pin_abort: cover property (@(posedge clk) disable iff (!resetn)
		state_q == fsp_pkg::FSP_BUSY && !mode_pin_s);
endmodule

// file: verilog/fsp_ctrl_map.svh
/*
 Constants of the flash self-programming controller: address limits,
 interrupt flag widths, operation timing counts.
 Assumes inclusion by bare name from design files.
*/
`ifndef FSP_CTRL_MAP_SVH
`define FSP_CTRL_MAP_SVH
// ===========================================
// Address limits
`define FSP_ADDR_W 16
`define FSP_BOOT0_LO 16'h0000
`define FSP_BOOT0_HI 16'h0FFF
`define FSP_COMMON_HI 16'h7FFF
// ===========================================
// Interrupt flag groups: four bytes of flags
`define FSP_IRQ_W 32
// ===========================================
// Operation timing (model of the flash array busy time)
`define FSP_CLK_MHZ 50
`define FSP_ERASE_US 20
`define FSP_WRITE_US 2
`define FSP_ERASE_CYC (`FSP_ERASE_US * `FSP_CLK_MHZ)
`define FSP_WRITE_CYC (`FSP_WRITE_US * `FSP_CLK_MHZ)
`endif

// file: verilog/fsp_pkg.sv
/*
 Types of the flash self-programming controller.
 Assumes nothing of its surroundings.
*/
package fsp_pkg;
	// ===========================================
	// Sequencer states
	typedef enum logic [2:0] {
		FSP_IDLE = 3'b000,
		FSP_READY = 3'b001,
		FSP_BUSY = 3'b010,
		FSP_PAUSED = 3'b011
	} fsp_state_t;
	// ===========================================
	// Operation codes
	typedef enum logic [1:0] {
		FSP_OP_NONE = 2'b00,
		FSP_OP_ERASE = 2'b01,
		FSP_OP_WRITE = 2'b10
	} fsp_op_t;
endpackage

// file: verilog/fsp_sync.sv
/*
 Two flip-flop synchroniser for a pin level.
 Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
module fsp_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic din,
	output logic dout
);
	logic meta_q;
	// ===========================================
	// Two stages; only the second stage is read
	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_q <= RESET_VAL;
			dout <= RESET_VAL;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule
